// *** verilog/remote_gate_consts.svh ***
/*
  Offsets, field positions, reset values and function slots of the remote
  input command gate. Assumes inclusion by bare name from the design files.
*/
`ifndef REMOTE_GATE_CONSTS_SVH
`define REMOTE_GATE_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define RG_CTRL_OFS        8'h00
`define RG_STATUS_OFS      8'h04
`define RG_LINES_OFS       8'h08
`define RG_MAP_BASE        8'h40
`define RG_MAP_WORDS       22

// ----------------------------------------------------------------------
// control fields and reset value
// ----------------------------------------------------------------------
`define RG_CTRL_ASSIGN_BIT 0
`define RG_CTRL_SELECT_BIT 1
`define RG_CTRL_PAUSE_BIT  2
`define RG_CTRL_RESET      3'h1

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define RG_ST_AUTO_BIT     0
`define RG_ST_FORCED_BIT   1
`define RG_ST_PROG_LSB     8
`define RG_ST_ROBOT_LSB    16
`define RG_ST_CMD_LSB      24

// ----------------------------------------------------------------------
// map entry fields
// ----------------------------------------------------------------------
`define RG_MAP_EN_BIT      5

// ----------------------------------------------------------------------
// function slots of the map
// ----------------------------------------------------------------------
`define RG_FN_START        0
`define RG_FN_PROG0        1
`define RG_FN_STOP         7
`define RG_FN_PAUSE        8
`define RG_FN_CONT         9
`define RG_FN_RESET        10
`define RG_FN_FORCED       11
`define RG_FN_RSEL         12
`define RG_FN_ROBOT0       13
`define RG_FN_ENERGISE     18
`define RG_FN_DEENERGISE   19
`define RG_FN_FULL         20
`define RG_FN_REDUCED      21

// ----------------------------------------------------------------------
// default input lines
// ----------------------------------------------------------------------
`define RG_DEF_START       5'h00
`define RG_DEF_PROG1       5'h01
`define RG_DEF_PROG2       5'h02
`define RG_DEF_PROG4       5'h03
`define RG_DEF_STOP        5'h04
`define RG_DEF_PAUSE       5'h05
`define RG_DEF_CONT        5'h06
`define RG_DEF_RESET       5'h07

// ----------------------------------------------------------------------
// robot numbering
// ----------------------------------------------------------------------
`define RG_ALL_ROBOTS      5'h00
`define RG_NUM_ROBOTS      5'h10

`endif

// *** verilog/remote_gate_pkg.sv ***
/*
  Types of the remote input command gate.
  Assumes nothing of its surroundings.
*/
package remote_gate_pkg;
  typedef logic [4:0] line_idx_t;
  typedef logic [5:0] map_entry_t;
  typedef logic [5:0] prog_num_t;
  typedef logic [4:0] robot_num_t;
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_START,
    CMD_STOP,
    CMD_PAUSE,
    CMD_CONTINUE,
    CMD_RESET,
    CMD_ROBOT_SELECT,
    CMD_ENERGISE,
    CMD_FULL_DRIVE,
    CMD_FORCED_LOW
  } cmd_e;
endpackage

// *** verilog/remote_line_sync.sv ***
/*
  Two-stage synchroniser with off-to-on edge detection for remote lines.
  Assumes asynchronous line levels and one clock hclk.
*/
`timescale 1ns/10ps
module remote_line_sync #(
  parameter int WIDTH = 24
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] lines_async,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] prev;

  // ----------------------------------------------------------------------
  // synchroniser and edge history
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta  <= '0;
      level <= '0;
      prev  <= '0;
    end else begin
      meta  <= lines_async;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise = level & ~prev;
endmodule // remote_line_sync

// *** verilog/remote_input_command_gate.sv ***
/*
  Remote input command gate: AHB-Lite slave, line-to-function map,
  acceptance gating and command pulses to the controller core.
  Assumes core status inputs on hclk and asynchronous remote lines.
*/
// Function
// - remote functions default to input lines 0-7 and output lines 0-7.
// - automatic-mode flag on when remote is assigned and selected as controller.
// - each function fires on its line's off-to-on edge while acceptance holds.
// - after an error only reset and forced low power are accepted until error clears.
// - start on line 0 needs ready, no error, halt, guard, pause, stop.
// - six weighted program bits, weights 1,2,4 on lines 1-3 by default.
// - stop on line 4 halts all tasks and commands.
// - pause on line 5 accepted only while running.
// - continue on line 6 needs paused, pause input off, stop input off.
// - reset on line 7 clears halt and error, needs ready.
// - forced low power accepted any time, even without automatic mode.
// - full drive rejected while forced low power is in effect.
// - forced low power also stops or pauses all tasks, as configured.
// - robot select strobe picks which robot the drive status outputs report.
// - five weighted robot select bits, none assigned by default.
// - energise needs ready, no halt, no guard, deenergise input off.
// - full drive needs ready, no halt, no guard, reduced drive input off.
// - automatic mode gates every remote function except forced low power, besides its own conditions.
// - program bits form main program 0 to 63, zero is base program.
// - robot bits give robot 1 to 16, zero means all robots.
`timescale 1ns/10ps
`include "remote_gate_consts.svh"
module remote_input_command_gate
  import remote_gate_pkg::*;
#(
  parameter int NUM_LINES = 24
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [NUM_LINES-1:0] remote_lines,
  input  wire logic                 status_ready,
  input  wire logic                 status_running,
  input  wire logic                 status_paused,
  input  wire logic                 status_error,
  input  wire logic                 emergency_halt_flag,
  input  wire logic                 guard_open_flag,
  input  wire logic                 status_fault,
  input  wire logic                 status_warning,
  input  wire logic [15:0]          robot_drives_on,
  input  wire logic [15:0]          robot_at_home,
  input  wire logic [15:0]          robot_full_drive,
  input  wire logic [15:0]          robot_cal_needed,
  output logic      [7:0]           remote_out,
  output logic                      automatic_operation_flag,
  output logic                      forced_reduced_drive,
  output logic                      cmd_start,
  output logic      [5:0]           cmd_program,
  output logic                      cmd_stop,
  output logic                      cmd_pause,
  output logic                      cmd_continue,
  output logic                      cmd_reset,
  output logic                      energise_drives_cmd,
  output logic                      full_drive_cmd,
  output logic      [4:0]           cmd_robot,
  output logic                      drives_energised_flag,
  output logic                      home_position_flag,
  output logic                      full_drive_flag,
  output logic                      calibration_needed_flag
);
  localparam int NFN = `RG_MAP_WORDS;

  logic [NUM_LINES-1:0] line_lvl;
  logic [NUM_LINES-1:0] line_rise;
  map_entry_t           map_q [NFN];
  logic [NFN-1:0]       fn_lvl;
  logic [NFN-1:0]       fn_rise;
  logic [2:0]           ctrl;
  prog_num_t            program_select_bits;
  robot_num_t           robot_bits;
  robot_num_t           robot_status_select;
  cmd_e                 last_cmd;
  logic                 wr_pend;
  logic [7:0]           wr_addr;
  logic [31:0]          next_rdata;
  logic                 addr_ok;
  logic                 gate;
  logic                 drive_ok;
  logic                 ok_start;
  logic                 ok_stop;
  logic                 ok_pause;
  logic                 ok_cont;
  logic                 ok_reset;
  logic                 ok_rsel;
  logic                 ok_energise;
  logic                 ok_full;
  logic                 forced_rise;
  logic                 next_auto;

  function automatic map_entry_t map_default(input int f);
    case (f)
      `RG_FN_START:     map_default = {1'b1, `RG_DEF_START};
      `RG_FN_PROG0:     map_default = {1'b1, `RG_DEF_PROG1};
      `RG_FN_PROG0 + 1: map_default = {1'b1, `RG_DEF_PROG2};
      `RG_FN_PROG0 + 2: map_default = {1'b1, `RG_DEF_PROG4};
      `RG_FN_STOP:      map_default = {1'b1, `RG_DEF_STOP};
      `RG_FN_PAUSE:     map_default = {1'b1, `RG_DEF_PAUSE};
      `RG_FN_CONT:      map_default = {1'b1, `RG_DEF_CONT};
      `RG_FN_RESET:     map_default = {1'b1, `RG_DEF_RESET};
      default:          map_default = 6'h00;
    endcase
  endfunction

  function automatic logic pick_robot(input logic [15:0] vec, input robot_num_t sel,
                                      input logic all_and);
    if (sel == `RG_ALL_ROBOTS) begin
      pick_robot = all_and ? &vec : |vec;
    end else if (sel <= `RG_NUM_ROBOTS) begin
      pick_robot = vec[4'(sel - 5'h01)];
    end else begin
      pick_robot = 1'b0;
    end
  endfunction

  // ----------------------------------------------------------------------
  // line synchroniser
  // ----------------------------------------------------------------------
  remote_line_sync #(
    .WIDTH       (NUM_LINES)
  ) u_sync (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .lines_async (remote_lines),
    .level       (line_lvl),
    .rise        (line_rise)
  );

  // ----------------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------------
  assign addr_ok = hsel && hready && htrans[1] && (haddr[1:0] == 2'h0)
                   && (haddr[31:8] == 24'h000000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= addr_ok && hwrite;
      wr_addr   <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (haddr[7:0] == `RG_CTRL_OFS) begin
      next_rdata[2:0] = ctrl;
    end else if (haddr[7:0] == `RG_STATUS_OFS) begin
      next_rdata[`RG_ST_AUTO_BIT]               = automatic_operation_flag;
      next_rdata[`RG_ST_FORCED_BIT]             = forced_reduced_drive;
      next_rdata[`RG_ST_PROG_LSB +: 6]          = program_select_bits;
      next_rdata[`RG_ST_ROBOT_LSB +: 5]         = robot_status_select;
      next_rdata[`RG_ST_CMD_LSB +: 4]           = last_cmd;
    end else if (haddr[7:0] == `RG_LINES_OFS) begin
      next_rdata[NUM_LINES-1:0] = line_lvl;
    end else begin
      for (int f = 0; f < NFN; f++) begin
        if (haddr[7:0] == 8'(`RG_MAP_BASE + 4 * f)) begin
          next_rdata[5:0] = map_q[f];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `RG_CTRL_RESET;
    end else if (wr_pend && wr_addr == `RG_CTRL_OFS) begin
      ctrl <= hwdata[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // function map and per-function edges
  // ----------------------------------------------------------------------
  for (genvar f = 0; f < NFN; f++) begin : g_fn
    line_idx_t idx;
    logic      hit;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        map_q[f] <= map_default(f);
      end else if (wr_pend && wr_addr == 8'(`RG_MAP_BASE + 4 * f)) begin
        map_q[f] <= hwdata[5:0];
      end
    end
    assign idx        = map_q[f][4:0];
    assign hit        = map_q[f][`RG_MAP_EN_BIT] && (32'(idx) < NUM_LINES);
    assign fn_lvl[f]  = hit && line_lvl[idx];
    assign fn_rise[f] = hit && line_rise[idx];
  end

  for (genvar b = 0; b < 6; b++) begin : g_prog
    assign program_select_bits[b] = fn_lvl[`RG_FN_PROG0 + b];
  end

  for (genvar b = 0; b < 5; b++) begin : g_robot
    assign robot_bits[b] = fn_lvl[`RG_FN_ROBOT0 + b];
  end

  // ----------------------------------------------------------------------
  // acceptance conditions
  // ----------------------------------------------------------------------
  assign gate        = automatic_operation_flag && !status_error;
  assign drive_ok    = gate && status_ready && !emergency_halt_flag && !guard_open_flag;
  assign ok_start    = drive_ok && !fn_lvl[`RG_FN_PAUSE] && !fn_lvl[`RG_FN_STOP];
  assign ok_stop     = gate;
  assign ok_pause    = gate && status_running;
  assign ok_cont     = gate && status_paused && !fn_lvl[`RG_FN_PAUSE]
                       && !fn_lvl[`RG_FN_STOP];
  assign ok_reset    = automatic_operation_flag && status_ready;
  assign ok_rsel     = gate;
  assign ok_energise = drive_ok && !fn_lvl[`RG_FN_DEENERGISE];
  assign ok_full     = drive_ok && !fn_lvl[`RG_FN_REDUCED]
                       && !fn_lvl[`RG_FN_FORCED];
  assign forced_rise = fn_rise[`RG_FN_FORCED];
  assign next_auto   = ctrl[`RG_CTRL_ASSIGN_BIT] && ctrl[`RG_CTRL_SELECT_BIT];

  // ----------------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      automatic_operation_flag <= 1'b0;
      remote_out               <= 8'h00;
      forced_reduced_drive     <= 1'b0;
    end else begin
      automatic_operation_flag <= next_auto;
      remote_out <= {status_warning, status_fault, guard_open_flag, emergency_halt_flag,
                     status_error, status_paused, status_running, status_ready};
      forced_reduced_drive <= fn_lvl[`RG_FN_FORCED];
    end
  end

  // ----------------------------------------------------------------------
  // command pulses
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_start           <= 1'b0;
      cmd_program         <= 6'h00;
      cmd_stop            <= 1'b0;
      cmd_pause           <= 1'b0;
      cmd_continue        <= 1'b0;
      cmd_reset           <= 1'b0;
      energise_drives_cmd <= 1'b0;
      full_drive_cmd      <= 1'b0;
      cmd_robot           <= 5'h00;
    end else begin
      cmd_start    <= fn_rise[`RG_FN_START] && ok_start;
      cmd_program  <= program_select_bits;
      cmd_stop     <= (fn_rise[`RG_FN_STOP] && ok_stop)
                      || (forced_rise && !ctrl[`RG_CTRL_PAUSE_BIT]);
      cmd_pause    <= (fn_rise[`RG_FN_PAUSE] && ok_pause)
                      || (forced_rise && ctrl[`RG_CTRL_PAUSE_BIT]);
      cmd_continue <= fn_rise[`RG_FN_CONT] && ok_cont;
      cmd_reset    <= fn_rise[`RG_FN_RESET] && ok_reset;
      energise_drives_cmd <= fn_rise[`RG_FN_ENERGISE] && ok_energise;
      full_drive_cmd      <= fn_rise[`RG_FN_FULL] && ok_full;
      cmd_robot    <= robot_bits;
    end
  end

  // ----------------------------------------------------------------------
  // robot status selection
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      robot_status_select <= `RG_ALL_ROBOTS;
    end else if (fn_rise[`RG_FN_RSEL] && ok_rsel) begin
      robot_status_select <= robot_bits;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drives_energised_flag   <= 1'b0;
      home_position_flag      <= 1'b0;
      full_drive_flag         <= 1'b0;
      calibration_needed_flag <= 1'b0;
    end else begin
      drives_energised_flag   <= pick_robot(robot_drives_on, robot_status_select, 1'b1);
      home_position_flag      <= pick_robot(robot_at_home, robot_status_select, 1'b1);
      full_drive_flag         <= pick_robot(robot_full_drive, robot_status_select, 1'b1);
      calibration_needed_flag <= pick_robot(robot_cal_needed, robot_status_select, 1'b0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_cmd <= CMD_NONE;
    end else if (forced_rise) begin
      last_cmd <= CMD_FORCED_LOW;
    end else if (fn_rise[`RG_FN_START] && ok_start) begin
      last_cmd <= CMD_START;
    end else if (fn_rise[`RG_FN_STOP] && ok_stop) begin
      last_cmd <= CMD_STOP;
    end else if (fn_rise[`RG_FN_PAUSE] && ok_pause) begin
      last_cmd <= CMD_PAUSE;
    end else if (fn_rise[`RG_FN_CONT] && ok_cont) begin
      last_cmd <= CMD_CONTINUE;
    end else if (fn_rise[`RG_FN_RESET] && ok_reset) begin
      last_cmd <= CMD_RESET;
    end else if (fn_rise[`RG_FN_RSEL] && ok_rsel) begin
      last_cmd <= CMD_ROBOT_SELECT;
    end else if (fn_rise[`RG_FN_ENERGISE] && ok_energise) begin
      last_cmd <= CMD_ENERGISE;
    end else if (fn_rise[`RG_FN_FULL] && ok_full) begin
      last_cmd <= CMD_FULL_DRIVE;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_forced_edge;
    forced_rise;
  endsequence

  sequence s_forced_effect;
    ##1 (forced_reduced_drive && (cmd_stop || cmd_pause));
  endsequence

  AST_OUT_LINES: assert property (
    remote_out[3] == $past(status_error) && remote_out[0] == $past(status_ready))
    else $error("remote output lines do not follow status");
  AST_AUTO: assert property (
    automatic_operation_flag == $past(next_auto))
    else $error("automatic mode flag wrong");
  AST_ONCE: assert property (
    cmd_start |=> !cmd_start)
    else $error("start fired twice for one edge");
  AST_ERR_BLOCK: assert property (
    $past(status_error) |-> !(cmd_start || cmd_continue || energise_drives_cmd
                              || full_drive_cmd))
    else $error("command accepted during error");
  AST_START: assert property (
    cmd_start |-> $past(status_ready && !emergency_halt_flag && !guard_open_flag
                        && automatic_operation_flag))
    else $error("start accepted without its conditions");
  AST_PROG: assert property (
    cmd_start |-> cmd_program == $past(program_select_bits))
    else $error("program number not taken with start");
  AST_PAUSE: assert property (
    (cmd_pause && !$past(forced_rise)) |-> $past(status_running))
    else $error("pause accepted while not running");
  AST_CONT: assert property (
    cmd_continue |-> $past(status_paused && !fn_lvl[`RG_FN_STOP]))
    else $error("continue accepted without paused");
  AST_RESET: assert property (
    cmd_reset |-> $past(status_ready))
    else $error("reset accepted without ready");
  AST_FORCED: assert property (
    s_forced_edge |-> s_forced_effect)
    else $error("forced low power not taken");
  AST_NO_FULL: assert property (
    full_drive_cmd |-> !forced_reduced_drive)
    else $error("full drive accepted under forced low power");
  AST_RSEL: assert property (
    (fn_rise[`RG_FN_RSEL] && ok_rsel) |=> robot_status_select == $past(robot_bits))
    else $error("robot status selection not updated");
  AST_ENERGISE: assert property (
    energise_drives_cmd |-> $past(status_ready && !fn_lvl[`RG_FN_DEENERGISE]))
    else $error("energise accepted without its conditions");
endmodule // remote_input_command_gate

// *** verif/remote_sequencer_model.sv ***
/*
  Model of the external sequencer that drives the remote input lines.
  Assumes the gate samples the lines on hclk; lines idle low.
*/
`timescale 1ns/10ps
module remote_sequencer_model (
  input  wire logic        hclk,
  output logic      [23:0] remote_lines
);
  initial remote_lines = '0;
  // one line level change, launched just after an edge
  task automatic drive(input int l, input logic v);
    @(posedge hclk);
    remote_lines[l] <= v;
  endtask
endmodule // remote_sequencer_model

// *** verif/remote_input_command_gate_tb.sv ***
/*
  Self-checking bench of the remote input command gate.
  Assumes the sequencer model and AHB-Lite register access.
*/
`timescale 1ns/10ps
module remote_input_command_gate_tb;
  import remote_gate_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, auto, fl;
  logic [31:0] haddr, hwdata, hrdata, r, rnd;
  logic [1:0]  htrans;
  logic        rdy, run, psd, err, halt, grd, flt, wrn, st, sp, ps, ct, rs, twice;
  logic [15:0] rb0, rb1, rb2, rb3;
  logic [23:0] lines;
  logic [7:0]  rout;
  logic [5:0]  prog, p;
  logic        en, fd, dflag;
  logic [6:0]  seen, want;
  logic [4:0]  rob;
  int          num_errors, tests_run;
  int          ln[8] = '{0, 4, 5, 6, 7, 8, 9, 10};

  remote_input_command_gate i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .remote_lines(lines), .status_ready(rdy), .status_running(run),
    .status_paused(psd), .status_error(err), .emergency_halt_flag(halt),
    .guard_open_flag(grd), .status_fault(flt), .status_warning(wrn),
    .robot_drives_on(rb0), .robot_at_home(rb1), .robot_full_drive(rb2),
    .robot_cal_needed(rb3), .remote_out(rout), .automatic_operation_flag(auto),
    .forced_reduced_drive(fl), .cmd_start(st), .cmd_program(prog), .cmd_stop(sp),
    .cmd_pause(ps), .cmd_continue(ct), .cmd_reset(rs), .energise_drives_cmd(en),
    .full_drive_cmd(fd), .cmd_robot(rob), .drives_energised_flag(dflag), .home_position_flag(),
    .full_drive_flag(), .calibration_needed_flag());
  remote_sequencer_model i_seq (.hclk, .remote_lines(lines));

  initial begin
    hclk = 0;
    forever #5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_cmd(input logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t pulses %b expected %b", $time, g, e);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // one line rise with random status, pulses gathered over six edges
  task automatic fire(input int l, input logic a, c);
    logic ok, dr;
    rnd = $urandom;
    i_seq.drive(1, rnd[8]);
    i_seq.drive(2, rnd[9]);
    i_seq.drive(3, rnd[10]);
    {rdy, run, psd, err, halt, grd, flt, wrn} <= rnd[7:0];
    {rb0, rb1} <= $urandom;
    {rb2, rb3} <= $urandom;
    @(posedge hclk);
    ok = a && !err;
    dr = ok && rdy && !halt && !grd;
    case (l)
      0: want = {6'h00, dr};
      4: want = {5'h00, ok, 1'b0};
      5: want = {4'h0, ok && run, 2'h0};
      6: want = {3'h0, ok && psd, 3'h0};
      7: want = {2'h0, a && rdy, 4'h0};
      9: want = {1'b0, dr, 5'h00};
      10: want = {dr, 6'h00};
      default: want = c ? 7'h04 : 7'h02;
    endcase
    i_seq.drive(l, 1);
    seen = 0;
    twice = 0;
    repeat (6) @(posedge hclk) begin
      twice |= |(seen & {fd, en, rs, ct, ps, sp, st});
      seen |= {fd, en, rs, ct, ps, sp, st};
      if (st) p = prog;
    end
    chk_cmd({twice, seen}, {1'b0, want});
    if (want[0]) chk({26'h0, p}, {29'h0, rnd[10:8]});
    chk({24'h0, rout}, {24'h0, wrn, flt, grd, halt, err, psd, run, rdy});
    chk({31'h0, auto}, {31'h0, a});
    if (l == 8) chk({31'h0, fl}, 32'h1);
    i_seq.drive(l, 0);
    repeat (2) @(posedge hclk);
  endtask

  task automatic results;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    results;
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {rdy, run, psd, err, halt, grd, flt, wrn, rb0, rb1, rb2, rb3} = '0;
    num_errors = 0;
    tests_run = 0;
    void'($urandom(71));
    repeat (20) @(posedge hclk);
    hresetn <= 1;
    ahb(0, 32'h0, 32'h0, r);
    chk(r, 32'h1);
    ahb(1, 32'h6C, 32'h28, r);
    ahb(0, 32'h6C, 32'h0, r);
    chk(r, 32'h28);
    ahb(0, 32'h0C, 32'h0, r);
    chk(r, 32'h0);
    ahb(1, 32'h88, 32'h29, r);
    ahb(1, 32'h90, 32'h2A, r);
    ahb(1, 32'h70, 32'h2B, r);
    ahb(1, 32'h74, 32'h2C, r);
    for (int i = 0; i < 96; i++) begin
      if (i == 32) ahb(1, 32'h0, 32'h3, r);
      if (i == 64) ahb(1, 32'h0, 32'h7, r);
      fire(ln[i % 8], i >= 32, i >= 64);
    end
    {rdy, run, psd, err, halt, grd, flt, wrn} <= 8'h80;
    i_seq.drive(8, 1);
    i_seq.drive(10, 1);
    seen = 0;
    repeat (6) @(posedge hclk) seen |= {fd, en, rs, ct, ps, sp, st};
    chk_cmd({1'b0, seen}, 8'h04);
    i_seq.drive(12, 1);
    i_seq.drive(11, 1);
    repeat (5) @(posedge hclk);
    chk({27'h0, rob}, 32'h1);
    chk({31'h0, dflag}, {31'h0, rb0[0]});
    ahb(0, 32'h4, 32'h0, r);
    chk(r, {8'h06, 3'h0, 5'h01, 5'h00, rnd[10:8], 8'h03});
    chk({31'h0, hresp}, 32'h0);
    ahb(0, 32'h8, 32'h0, r);
    chk(r, {8'h00, lines});
    results;
  end
endmodule // remote_input_command_gate_tb
